// file: shared/pbs_pkg.sv
package pbs_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned PBS_ADDR_W = 18;
  localparam int unsigned PBS_DATA_W = 36;
  localparam int unsigned PBS_LANES = 4;
  localparam int unsigned PBS_LANE_W = 9;
  localparam int unsigned PBS_DEPTH = 262144;
  localparam int unsigned PBS_BURST_W = 2;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic PBS_DIR_READ = 1'b1;
  localparam logic PBS_ADV_LOAD = 1'b0;
  localparam logic [1:0] PBS_CNT_RST = 2'h0;
  localparam logic [1:0] PBS_CNT_ONE = 2'h1;
  localparam logic [PBS_DATA_W-1:0] PBS_DATA_RST = 36'h0;
  localparam logic [PBS_ADDR_W-1:0] PBS_ADDR_RST = 18'h0;

  typedef enum logic [2:0] {
    PBS_ST_IDLE = 3'b001,
    PBS_ST_READ = 3'b010,
    PBS_ST_WRITE = 3'b100
  } pbs_op_type;
endpackage

// file: hdl/pbs_core.sv
module pbs_core
  import pbs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Memory bus control
  input wire logic cycle_hold_n,
  input wire logic advance_or_load,
  input wire logic read_not_write,
  input wire logic select_first_n,
  input wire logic select_second,
  input wire logic select_third_n,
  input wire logic [pbs_pkg::PBS_LANES-1:0] byte_lane_write_n,
  input wire logic linear_order,
  input wire logic output_enable_n,
  input wire logic [pbs_pkg::PBS_ADDR_W-1:0] addr,
  // Data pins
  input wire logic [pbs_pkg::PBS_DATA_W-1:0] dq_in,
  output logic [pbs_pkg::PBS_DATA_W-1:0] dq_out,
  output logic dq_oe_n
);
  import pbs_pkg::*;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic enabled;
  logic selected;
  logic load_cyc;
  logic adv_cyc;
  assign enabled = ~cycle_hold_n;
  assign selected = ~select_first_n & ~select_third_n & select_second;
  assign load_cyc = enabled & (advance_or_load == PBS_ADV_LOAD);
  assign adv_cyc = enabled & (advance_or_load != PBS_ADV_LOAD);

  // ----------------------------------------------------------------
  // Pipeline state
  // ----------------------------------------------------------------
  pbs_op_type op_q, op_d;
  pbs_op_type s1_op_q, s1_op_d;
  pbs_op_type s2_op_q, s2_op_d;
  logic [PBS_ADDR_W-1:0] base_q, base_d;
  logic [1:0] cnt_q, cnt_d;
  logic [PBS_ADDR_W-1:0] s1_addr_q, s1_addr_d;
  logic [PBS_ADDR_W-1:0] s2_addr_q, s2_addr_d;
  logic [PBS_LANES-1:0] s1_be_q, s1_be_d;
  logic [PBS_LANES-1:0] s2_be_q, s2_be_d;
  logic [PBS_DATA_W-1:0] rd_q, rd_d;
  logic drive_q, drive_d;
  logic [PBS_ADDR_W-1:0] cur_addr;
  logic [1:0] low_bits;
  logic [PBS_DATA_W-1:0] mem [PBS_DEPTH];

  // Burst order: interleaved xors the count, linear adds it
  always_comb
  begin
    if (linear_order)
      low_bits = base_d[1:0] + cnt_d;
    else
      low_bits = base_d[1:0] ^ cnt_d;
    cur_addr = {base_d[PBS_ADDR_W-1:2], low_bits};
  end

  always_comb
  begin
    op_d = op_q;
    base_d = base_q;
    cnt_d = cnt_q;
    s1_op_d = s1_op_q;
    s2_op_d = s2_op_q;
    s1_addr_d = s1_addr_q;
    s2_addr_d = s2_addr_q;
    s1_be_d = s1_be_q;
    s2_be_d = s2_be_q;
    if (enabled)
    begin
      if (load_cyc)
      begin
        if (selected)
        begin
          op_d = (read_not_write == PBS_DIR_READ) ? PBS_ST_READ : PBS_ST_WRITE;
          base_d = addr;
          cnt_d = PBS_CNT_RST;
        end
        else
          op_d = PBS_ST_IDLE;
      end
      else
      begin
        // Advance only steps an open burst; idle advance is a no-op
        case (op_q)
          PBS_ST_READ, PBS_ST_WRITE:
          begin
            if (adv_cyc)
              cnt_d = cnt_q + PBS_CNT_ONE;
          end
          default:
            cnt_d = cnt_q;
        endcase
      end
      // Stage 1 takes this cycle's operation and byte enables
      s1_op_d = op_d;
      s1_addr_d = cur_addr;
      s1_be_d = byte_lane_write_n;
      // Stage 2 is the data cycle, two enabled edges after command
      s2_op_d = s1_op_q;
      s2_addr_d = s1_addr_q;
      s2_be_d = s1_be_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      op_q <= PBS_ST_IDLE;
      base_q <= PBS_ADDR_RST;
      cnt_q <= PBS_CNT_RST;
      s1_op_q <= PBS_ST_IDLE;
      s2_op_q <= PBS_ST_IDLE;
      s1_addr_q <= PBS_ADDR_RST;
      s2_addr_q <= PBS_ADDR_RST;
      s1_be_q <= '1;
      s2_be_q <= '1;
    end
    else
    begin
      op_q <= op_d;
      base_q <= base_d;
      cnt_q <= cnt_d;
      s1_op_q <= s1_op_d;
      s2_op_q <= s2_op_d;
      s1_addr_q <= s1_addr_d;
      s2_addr_q <= s2_addr_d;
      s1_be_q <= s1_be_d;
      s2_be_q <= s2_be_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  // Registered so the word stands unchanged across any number of
  // suspended edges.
  always_comb
  begin
    rd_d = rd_q;
    drive_d = drive_q;
    if (enabled)
    begin
      if (s1_op_q == PBS_ST_READ)
        rd_d = mem[s1_addr_q];
      drive_d = (s1_op_q == PBS_ST_READ);
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_q <= PBS_DATA_RST;
      drive_q <= 1'b0;
    end
    else
    begin
      rd_q <= rd_d;
      drive_q <= drive_d;
    end
  end

  // ----------------------------------------------------------------
  // Write array, one lane per byte enable
  // ----------------------------------------------------------------
  // Data sampled on the edge that closes the data cycle, even if
  // the chip is deselected then; overlaps new loads freely.
  logic [PBS_DATA_W-1:0] wr_word;
  for (genvar g = 0; g < PBS_LANES; g++)
  begin : g_lane
    assign wr_word[g*PBS_LANE_W +: PBS_LANE_W] = s2_be_q[g] ? mem[s2_addr_q][g*PBS_LANE_W +: PBS_LANE_W]
      : dq_in[g*PBS_LANE_W +: PBS_LANE_W];
    lane_store_a: assert property (@(posedge sys_clk) disable iff (rst)
      enabled && s2_op_q == PBS_ST_WRITE && !s2_be_q[g] |=>
      mem[$past(s2_addr_q)][g*PBS_LANE_W +: PBS_LANE_W] == $past(dq_in[g*PBS_LANE_W +: PBS_LANE_W]))
      else $error("write lane not stored");
  end

  // One writer for the array; masked lanes write back what they hold
  always_ff @(posedge sys_clk)
  begin
    if (enabled && s2_op_q == PBS_ST_WRITE)
      mem[s2_addr_q] <= wr_word;
  end

  // ----------------------------------------------------------------
  // Check helpers
  // ----------------------------------------------------------------
  // Long suspensions exceed any repetition count, so the run of
  // suspended edges and the word seen at its start are kept here.
  logic [3:0] hold_run_q, hold_run_d;
  logic [PBS_DATA_W-1:0] held_word_q, held_word_d;

  always_comb
  begin
    hold_run_d = hold_run_q;
    held_word_d = held_word_q;
    if (enabled)
      hold_run_d = 4'h0;
    else
    begin
      if (hold_run_q == 4'h0)
        held_word_d = dq_out;
      if (hold_run_q != 4'hf)
        hold_run_d = hold_run_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hold_run_q <= 4'h0;
      held_word_q <= PBS_DATA_RST;
    end
    else
    begin
      hold_run_q <= hold_run_d;
      held_word_q <= held_word_d;
    end
  end

  // ----------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------
  // Data and drive_q are registered; output enable gates the driver directly so it
  // can float the bus at any time.
  assign dq_out = rd_q;
  assign dq_oe_n = ~drive_q | output_enable_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  read_float_a: assert property (@(posedge sys_clk) disable iff (rst)
    output_enable_n |-> dq_oe_n)
    else $error("bus driven with output enable high");
  hold_state_a: assert property (@(posedge sys_clk) disable iff (rst)
    cycle_hold_n |=> $stable(rd_q) && $stable(drive_q) && $stable(cnt_q))
    else $error("state moved on a suspended edge");
  read_latency_a: assert property (@(posedge sys_clk) disable iff (rst)
    load_cyc && selected && read_not_write ##1 enabled |=> drive_q)
    else $error("read data not driven two enabled edges after load");
  suspend_latency_a: assert property (@(posedge sys_clk) disable iff (rst)
    load_cyc && selected && read_not_write ##1 !enabled ##1 enabled ##1 enabled |-> drive_q)
    else $error("suspended edge counted in read latency");
  desel_float_a: assert property (@(posedge sys_clk) disable iff (rst)
    load_cyc && !selected ##1 enabled && (s1_op_q != PBS_ST_READ) |=> !drive_q)
    else $error("bus still driven after idle deselect");
  desel_complete_a: assert property (@(posedge sys_clk) disable iff (rst)
    enabled && s1_op_q == PBS_ST_READ && load_cyc && !selected |=> drive_q)
    else $error("pending read lost on deselect");
  counter_step_a: assert property (@(posedge sys_clk) disable iff (rst)
    adv_cyc && op_q != PBS_ST_IDLE |=> cnt_q == $past(cnt_q) + PBS_CNT_ONE)
    else $error("burst counter did not advance");
  write_stage_a: assert property (@(posedge sys_clk) disable iff (rst)
    load_cyc && selected && !read_not_write |=> s1_op_q == PBS_ST_WRITE)
    else $error("write load not queued");
  select_decode_a: assert property (@(posedge sys_clk) disable iff (rst)
    load_cyc && (select_first_n || select_third_n || !select_second) |=> op_q == PBS_ST_IDLE)
    else $error("load taken while deselected");
  reset_float_a: assert property (@(posedge sys_clk)
    $fell(rst) |-> dq_oe_n)
    else $error("bus driven after reset");
  oe_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
    drive_q && !output_enable_n |-> !dq_oe_n)
    else $error("read word not driven with output enable low");
  hold_pipe_a: assert property (@(posedge sys_clk) disable iff (rst)
    cycle_hold_n |=> $stable(op_q) && $stable(base_q) && $stable(s1_op_q) && $stable(s2_op_q)
    && $stable(s1_addr_q) && $stable(s2_addr_q))
    else $error("pipeline moved on a suspended edge");
  write_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    enabled && s1_op_q == PBS_ST_WRITE |=> !drive_q)
    else $error("bus driven in a write data cycle");
  write_carry_a: assert property (@(posedge sys_clk) disable iff (rst)
    enabled && s1_op_q == PBS_ST_WRITE |=> s2_op_q == PBS_ST_WRITE)
    else $error("queued write lost");
  burst_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
    adv_cyc && op_q != PBS_ST_IDLE && cnt_q == 2'h3 |=> cnt_q == PBS_CNT_RST)
    else $error("burst counter did not wrap");
  load_base_a: assert property (@(posedge sys_clk) disable iff (rst)
    load_cyc && selected |=> cnt_q == PBS_CNT_RST && base_q == $past(addr))
    else $error("load did not restart the burst");
  held_word_a: assert property (@(posedge sys_clk) disable iff (rst)
    hold_run_q != 4'h0 |-> dq_out == held_word_q)
    else $error("read word changed during suspension");

  burst_cov: cover property (@(posedge sys_clk) disable iff (rst)
    load_cyc && selected ##1 adv_cyc [*3] ##1 load_cyc && selected);
  suspend_cov: cover property (@(posedge sys_clk) disable iff (rst)
    drive_q && !enabled ##1 !enabled ##1 enabled);
  desel_cov: cover property (@(posedge sys_clk) disable iff (rst)
    load_cyc && selected && !read_not_write ##1 load_cyc && !selected);
  write_hold_cov: cover property (@(posedge sys_clk) disable iff (rst)
    load_cyc && selected && !read_not_write ##1 !enabled ##1 !enabled ##1 enabled);
  long_hold_cov: cover property (@(posedge sys_clk) disable iff (rst)
    drive_q && hold_run_q == 4'h2);
endmodule

// file: testbench/pbs_ctl_model.sv
module pbs_ctl_model
  import pbs_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Command and straps
  output logic cycle_hold_n,
  output logic advance_or_load,
  output logic read_not_write,
  output logic select_first_n,
  output logic select_second,
  output logic select_third_n,
  output logic [pbs_pkg::PBS_LANES-1:0] byte_lane_write_n,
  output logic linear_order,
  output logic output_enable_n,
  output logic [pbs_pkg::PBS_ADDR_W-1:0] addr,
  // Write data
  output logic [pbs_pkg::PBS_DATA_W-1:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lin = 1'b1;
  logic oe = 1'b0;
  initial
  begin
    {cycle_hold_n, advance_or_load, read_not_write} = 3'h7;
    {select_first_n, select_second, select_third_n} = 3'h5;
    byte_lane_write_n = 4'h0;
    {linear_order, output_enable_n} = 2'h2;
    addr = PBS_ADDR_RST;
    dq_in = PBS_DATA_RST;
  end
  // One bus cycle, launched just after a rising edge
  task automatic cyc(input logic h, adv, rnw, input logic [2:0] s, input logic [PBS_ADDR_W-1:0] a,
    input logic dv = 1'b0, input logic [PBS_DATA_W-1:0] d = 36'h0);
    @(posedge sys_clk);
    {cycle_hold_n, advance_or_load, read_not_write} <= {h, adv, rnw};
    {select_first_n, select_second, select_third_n} <= s;
    {linear_order, output_enable_n} <= {lin, oe};
    addr <= a;
    // Idle lines toggle so a stale word is never stored by luck
    dq_in <= dv ? d : ~dq_in;
    #1;
  endtask
endmodule

// file: testbench/pipelined_burst_sram_cycles_tb.sv
module pipelined_burst_sram_cycles_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pbs_pkg::*;
  localparam logic [2:0] SEL = 3'h2;
  logic sys_clk, rst, cycle_hold_n, advance_or_load, read_not_write, linear_order, output_enable_n;
  logic select_first_n, select_second, select_third_n, dq_oe_n;
  logic [PBS_LANES-1:0] byte_lane_write_n;
  logic [PBS_ADDR_W-1:0] addr;
  logic [PBS_DATA_W-1:0] dq_in, dq_out;
  logic [PBS_DATA_W-1:0] w[8];
  int mismatches, checks_done, cycles;
  pbs_core DUT (.sys_clk, .rst, .cycle_hold_n, .advance_or_load, .read_not_write, .select_first_n,
    .select_second, .select_third_n, .byte_lane_write_n, .linear_order, .output_enable_n, .addr,
    .dq_in, .dq_out, .dq_oe_n);
  pbs_ctl_model u_ctl (.sys_clk, .cycle_hold_n, .advance_or_load, .read_not_write, .select_first_n,
    .select_second, .select_third_n, .byte_lane_write_n, .linear_order, .output_enable_n, .addr, .dq_in);
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [PBS_DATA_W:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [PBS_DATA_W-1:0] e);
    chk("read word", {dq_oe_n, dq_out}, {1'b0, e});
  endtask
  task automatic fl();
    chk("bus float", 37'(dq_oe_n), 37'h1);
  endtask
  task automatic ld(input logic rnw, input logic [PBS_ADDR_W-1:0] a, input logic dv = 1'b0,
    input logic [PBS_DATA_W-1:0] d = 36'h0);
    u_ctl.cyc(1'b0, 1'b0, rnw, SEL, a, dv, d);
  endtask
  // Advance, deselect or held cycle; a held cycle carries a junk load that must be ignored
  task automatic nl(input logic h, adv, input logic [2:0] s, input logic dv = 1'b0,
    input logic [PBS_DATA_W-1:0] d = 36'h0);
    u_ctl.cyc(h, adv, 1'b1, s, 18'h3ffff, dv, d);
  endtask
  task automatic s_burst();
    ld(1'b0, 18'h00011);
    nl(1'b0, 1'b1, SEL);
    nl(1'b0, 1'b1, SEL, 1'b1, w[0]);
    nl(1'b0, 1'b1, SEL, 1'b1, w[1]);
    nl(1'b0, 1'b1, SEL, 1'b1, w[2]);
    ld(1'b0, 18'h00030, 1'b1, w[3]);
    u_ctl.lin = 1'b0;
    nl(1'b0, 1'b0, 3'h5, 1'b1, w[4]);
    nl(1'b0, 1'b0, 3'h5, 1'b1, w[5]);
    ld(1'b1, 18'h00011);
    nl(1'b0, 1'b1, SEL);
    nl(1'b0, 1'b1, SEL); rd(w[4]);
    nl(1'b0, 1'b1, SEL); rd(w[3]);
    ld(1'b1, 18'h00030); rd(w[2]);
    nl(1'b0, 1'b0, 3'h5); rd(w[1]);
    nl(1'b0, 1'b0, 3'h5); rd(w[5]);
    nl(1'b0, 1'b0, 3'h5); fl();
  endtask
  task automatic s_hold();
    ld(1'b1, 18'h00011);
    nl(1'b1, 1'b0, SEL);
    ld(1'b1, 18'h00012);
    nl(1'b1, 1'b0, SEL); rd(w[4]);
    nl(1'b1, 1'b0, SEL); rd(w[4]);
    u_ctl.oe = 1'b1;
    ld(1'b1, 18'h00013); chk("oe gate", {dq_oe_n, dq_out}, {1'b1, w[4]});
    u_ctl.oe = 1'b0;
    nl(1'b0, 1'b0, 3'h5); rd(w[1]);
    nl(1'b0, 1'b0, 3'h5); rd(w[2]);
    ld(1'b0, 18'h00014);
    nl(1'b1, 1'b0, SEL);
    ld(1'b0, 18'h00015);
    nl(1'b1, 1'b0, SEL);
    nl(1'b1, 1'b0, SEL);
    nl(1'b0, 1'b0, 3'h5, 1'b1, w[6]);
    nl(1'b0, 1'b0, 3'h5, 1'b1, w[7]);
    ld(1'b1, 18'h00014);
    ld(1'b1, 18'h00015);
    nl(1'b0, 1'b0, 3'h5); rd(w[6]);
    nl(1'b0, 1'b0, 3'h5); rd(w[7]);
  endtask
  task automatic s_sel();
    for (int i = 0; i < 8; i++)
      if (i != 2)
      begin
        u_ctl.cyc(1'b0, 1'b0, 1'b1, 3'(i), 18'h00011);
        nl(1'b0, 1'b0, 3'h5);
        nl(1'b0, 1'b0, 3'h5); fl();
      end
  endtask
  task automatic complete_run();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Whole run needs under 100 cycles; the ceiling leaves ample slack
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles > 1000)
    begin
      mismatches++;
      complete_run();
    end
  end
  initial
  begin
    rst = 1'b1;
    for (int i = 0; i < 8; i++) w[i] = 36'h5_a5c3_0f00 ^ {4'(i), 28'h0, 4'(i)};
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    fl();
    s_burst();
    s_hold();
    s_sel();
    complete_run();
  end
endmodule
